// [rtl/isa_bus_interface.sv]
// Expansion bus interface: initiator for host, DMA and refresh,
// target for bus masters. Pins asynchronous, host side on clk_sys.
`timescale 1ns/1ps
module isa_bus_interface (
    // System
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Host and DMA cycle request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_is_io,
    input  wire logic        req_write,
    input  wire logic        req_bhe,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic             req_done,
    output logic      [15:0] req_rdata,
    // Refresh
    input  wire logic        refresh_req,
    output logic             host_bus_claim,
    output logic      [7:0]  refresh_addr,
    // DMA
    input  wire logic        dma_owner,
    input  wire logic        dma_last,
    input  wire logic [2:0]  dma_channel,
    output logic      [2:0]  encoded_dma_acknowledges,
    output logic             terminal_count,
    // Bus master target side
    output logic             master_owner,
    input  wire logic        master_target_hit,
    input  wire logic        master_access_done,
    output logic      [3:0]  master_strobes,
    output logic      [19:0] master_addr,
    // Error
    input  wire logic        nmi_enable,
    output logic             nmi,
    // Address and data pins
    output logic      [6:0]  la_out,
    output logic             la_oe,
    input  wire logic [19:0] sa_in,
    output logic      [19:0] sa_out,
    output logic             sa_oe,
    input  wire logic [15:0] sd_in,
    output logic      [15:0] sd_out,
    output logic             sd_oe,
    input  wire logic        sbhe_n_in,
    output logic             sbhe_n_out,
    // Command pins
    input  wire logic        memr_n_in,
    input  wire logic        memw_n_in,
    input  wire logic        ior_n_in,
    input  wire logic        iow_n_in,
    output logic             memr_n_out,
    output logic             memw_n_out,
    output logic             ior_n_out,
    output logic             iow_n_out,
    output logic             cmd_oe,
    output logic             smemr_n,
    output logic             smemw_n,
    // Control pins
    output logic             ale,
    output logic             aen,
    input  wire logic        iochrdy_in,
    output logic             iochrdy_out,
    output logic             iochrdy_oe,
    input  wire logic        ref_n_in,
    output logic             ref_n_out,
    output logic             ref_n_oe,
    input  wire logic        master_n,
    input  wire logic        mcs16_n,
    input  wire logic        iochck_n,
    // Clock chip and boot memory
    output logic             clock_chip_address_strobe_n,
    output logic             clock_chip_write_strobe_n,
    output logic             clock_chip_data_strobe_n,
    output logic             boot_or_clock_chip_select_n,
    // Multiplexed requests
    input  wire logic [3:0]  muxed_interrupt_requests,
    input  wire logic [1:0]  muxed_dma_requests,
    output logic             expansion_bus_clock,
    output logic             expansion_bus_clock_double,
    output logic      [15:0] irq_to_controller,
    output logic      [7:0]  dreq_to_controller
);
    // ******************************
    // State
    // ******************************
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_SETUP   = 7'h02,
        ST_ACTIVE  = 7'h04,
        ST_RECOVER = 7'h08,
        ST_REF_HST = 7'h10,
        ST_REF_ISA = 7'h20,
        ST_SPARE   = 7'h40
    } ibi_state_t;

    typedef struct packed {
        ibi_state_t  state;
        logic [4:0]  cnt;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        is_io;
        logic        write;
        logic        bhe;
        logic        dma;
        logic        wide;
        logic        refc;
        logic        mref;
        logic        ref_pend;
        logic [7:0]  ref_addr;
        logic        done;
        logic [8:0]  sy1;
        logic [8:0]  sy2;
        logic        ref_prev;
        logic        nmi;
        logic        ale;
        logic        rdy_hold;
        logic [2:0]  dack;
        logic        tc;
        logic [19:0] maddr;
    } ibi_regs_t;
    ibi_regs_t r_r, r_nxt;

    // ******************************
    // Decode helpers
    // ******************************
    function automatic logic below_meg(input logic [23:0] a);
        return a < ibi_pkg::ONE_MEG;
    endfunction

    function automatic logic port_is(input logic [23:0] a,
                                     input logic [15:0] p);
        return a[15:0] == p;
    endfunction

    logic own_m;
    logic cyc;
    logic cmd;
    logic rd_mem;
    logic wr_mem;
    logic rd_io;
    logic wr_io;
    logic [3:0] m_cmd;

    always_comb begin
        own_m  = !r_r.sy2[ibi_pkg::SY_MASTER];
        cyc    = r_r.state inside {ST_SETUP, ST_ACTIVE};
        cmd    = r_r.state == ST_ACTIVE;
        // DMA runs memory and I/O commands together, write meaning memory write
        rd_mem = (cmd && !r_r.write && (r_r.dma || !r_r.is_io))
               || r_r.state == ST_REF_ISA;
        wr_mem = cmd && r_r.write && (r_r.dma || !r_r.is_io);
        rd_io  = cmd && (r_r.dma ? r_r.write : (r_r.is_io && !r_r.write));
        wr_io  = cmd && (r_r.dma ? !r_r.write : (r_r.is_io && r_r.write));
        m_cmd  = ~r_r.sy2[ibi_pkg::SY_MEMW:ibi_pkg::SY_IOR];
    end

    // ******************************
    // Next state
    // ******************************
    always_comb begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        r_nxt.sy1  = {memw_n_in, memr_n_in, iow_n_in, ior_n_in, ref_n_in,
                      mcs16_n, iochck_n, iochrdy_in, master_n};
        r_nxt.sy2  = r_r.sy1;
        r_nxt.ref_prev = r_r.sy2[ibi_pkg::SY_REF];
        r_nxt.nmi  = !r_r.sy2[ibi_pkg::SY_CHK] && nmi_enable;
        r_nxt.ale  = r_r.state inside {ST_SETUP, ST_REF_HST, ST_REF_ISA}
                   || dma_owner || own_m;
        r_nxt.rdy_hold = own_m && master_target_hit
                       && !master_access_done && (m_cmd != 4'h0);
        r_nxt.dack = (dma_owner && cyc) ? dma_channel
                                        : ibi_pkg::DACK_IDLE;
        r_nxt.tc   = dma_owner && dma_last && cyc && r_r.dma;
        if (own_m && m_cmd != 4'h0) begin
            r_nxt.maddr = sa_in;
        end
        case (r_r.state)
            ST_IDLE: begin
                if (r_r.ref_pend && !own_m) begin
                    r_nxt.state = ST_REF_HST;
                    r_nxt.cnt   = 5'(ibi_pkg::REF_HOST_CLKS - 1);
                    r_nxt.addr  = {16'h0000, r_r.ref_addr};
                    r_nxt.refc  = 1'b1;
                    r_nxt.mref  = 1'b0;
                end else if (own_m && r_r.ref_prev
                             && !r_r.sy2[ibi_pkg::SY_REF]) begin
                    r_nxt.state = ST_REF_HST;
                    r_nxt.cnt   = 5'(ibi_pkg::REF_HOST_CLKS - 1);
                    r_nxt.refc  = 1'b1;
                    r_nxt.mref  = 1'b1;
                end else if (req_valid && !own_m) begin
                    r_nxt.state = ST_SETUP;
                    r_nxt.cnt   = 5'(ibi_pkg::SETUP_CYC - 1);
                    r_nxt.addr  = req_addr;
                    r_nxt.wdata = req_wdata;
                    r_nxt.is_io = req_is_io;
                    r_nxt.write = req_write;
                    r_nxt.bhe   = req_bhe;
                    r_nxt.dma   = dma_owner;
                    r_nxt.refc  = 1'b0;
                end
            end
            ST_SETUP: begin
                if (r_r.cnt != 5'h00) begin
                    r_nxt.cnt = r_r.cnt - 5'h01;
                end else begin
                    r_nxt.wide  = !r_r.is_io && !r_r.dma
                                && !r_r.sy2[ibi_pkg::SY_MCS16];
                    r_nxt.state = ST_ACTIVE;
                    r_nxt.cnt   = r_nxt.wide ? 5'(ibi_pkg::CMD16_CYC - 1)
                                             : 5'(ibi_pkg::CMD8_CYC - 1);
                end
            end
            ST_ACTIVE, ST_REF_ISA: begin
                if (r_r.cnt != 5'h00) begin
                    r_nxt.cnt = r_r.cnt - 5'h01;
                end else if (r_r.sy2[ibi_pkg::SY_RDY]) begin
                    r_nxt.rdata = sd_in;
                    r_nxt.state = ST_RECOVER;
                    r_nxt.cnt   = 5'(ibi_pkg::RECOV_CYC - 1);
                end
            end
            ST_RECOVER: begin
                if (r_r.cnt != 5'h00) begin
                    r_nxt.cnt = r_r.cnt - 5'h01;
                end else begin
                    r_nxt.done  = !r_r.refc;
                    r_nxt.state = ST_IDLE;
                end
            end
            ST_REF_HST: begin
                if (r_r.cnt != 5'h00) begin
                    r_nxt.cnt = r_r.cnt - 5'h01;
                end else begin
                    r_nxt.ref_addr = r_r.ref_addr + 8'h01;
                    r_nxt.state = r_r.mref ? ST_IDLE : ST_REF_ISA;
                    r_nxt.cnt   = 5'(ibi_pkg::CMD8_CYC - 1);
                end
            end
            default: begin
                r_nxt.state = ST_IDLE;
            end
        endcase
        // A new refresh request wins over the clear on take-up
        r_nxt.ref_pend = refresh_req
                       || (r_r.ref_pend && r_nxt.state != ST_REF_HST);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_r          <= '0;
            r_r.state    <= ST_IDLE;
            r_r.ref_addr <= ibi_pkg::REF_ADDR_RST;
            r_r.sy1      <= ibi_pkg::SY_RST;
            r_r.sy2      <= ibi_pkg::SY_RST;
            r_r.ref_prev <= 1'b1;
            r_r.dack     <= ibi_pkg::DACK_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ******************************
    // Pin drive
    // ******************************
    assign req_ready  = r_r.state == ST_IDLE && !own_m && !r_r.ref_pend;
    assign req_done   = r_r.done;
    assign req_rdata  = r_r.rdata;
    assign host_bus_claim = r_r.state == ST_REF_HST;
    assign refresh_addr   = r_r.ref_addr;
    assign master_owner   = own_m;
    assign master_strobes = m_cmd;
    assign master_addr    = r_r.maddr;
    assign nmi        = r_r.nmi;
    assign la_out     = r_r.addr[23:17];
    assign la_oe      = !own_m;
    assign sa_out     = r_r.addr[19:0];
    assign sa_oe      = !own_m;
    assign cmd_oe     = !own_m;
    assign sd_out     = r_r.wdata;
    assign sd_oe      = !own_m && r_r.write && cyc && !r_r.refc;
    assign sbhe_n_out = !(r_r.bhe && cyc);
    assign memr_n_out = !rd_mem;
    assign memw_n_out = !wr_mem;
    assign ior_n_out  = !rd_io;
    assign iow_n_out  = !wr_io;
    assign smemr_n    = !(rd_mem && (below_meg(r_r.addr)
                                     || r_r.state == ST_REF_ISA));
    assign smemw_n    = !(wr_mem && below_meg(r_r.addr));
    assign ale        = r_r.ale;
    assign aen        = dma_owner;
    assign iochrdy_out = 1'b0;
    assign iochrdy_oe  = r_r.rdy_hold;
    assign ref_n_out  = 1'b0;
    assign ref_n_oe   = r_r.state == ST_REF_ISA;
    assign encoded_dma_acknowledges = r_r.dack;
    assign terminal_count = r_r.tc;
    assign clock_chip_address_strobe_n =
        !(wr_io && !r_r.dma && port_is(r_r.addr, ibi_pkg::PORT_RTC_ADDR));
    assign clock_chip_write_strobe_n =
        !(wr_io && !r_r.dma && port_is(r_r.addr, ibi_pkg::PORT_RTC_DATA));
    assign clock_chip_data_strobe_n =
        !(rd_io && !r_r.dma && port_is(r_r.addr, ibi_pkg::PORT_RTC_DATA));
    assign boot_or_clock_chip_select_n = !(cyc && !r_r.dma && !r_r.refc
        && (r_r.is_io ? (port_is(r_r.addr, ibi_pkg::PORT_RTC_ADDR)
                         || port_is(r_r.addr, ibi_pkg::PORT_RTC_DATA))
                      : (r_r.addr >= ibi_pkg::BOOT_BASE
                         && below_meg(r_r.addr))));

    // ******************************
    // Request multiplexer
    // ******************************
    ibi_mux_if mux ();

    ibi_clk_div u_div (
        .clk_sys                    (clk_sys),
        .reset                      (reset),
        .mux                        (mux.gen),
        .expansion_bus_clock        (expansion_bus_clock),
        .expansion_bus_clock_double (expansion_bus_clock_double)
    );

    ibi_req_demux u_dmx (
        .clk_sys                  (clk_sys),
        .reset                    (reset),
        .mux                      (mux.take),
        .muxed_interrupt_requests (muxed_interrupt_requests),
        .muxed_dma_requests       (muxed_dma_requests),
        .irq_to_controller        (irq_to_controller),
        .dreq_to_controller       (dreq_to_controller)
    );
endmodule // isa_bus_interface

// [rtl/ibi_pkg.sv]
// Constants shared by the expansion bus interface.
// Assumes a 40 MHz system clock.
package ibi_pkg;
    // ******************************
    // Timing
    // ******************************
    localparam int CLK_MHZ     = 40;
    localparam int SETUP_NS    = 75;
    localparam int CMD16_NS    = 250;
    localparam int CMD8_NS     = 500;
    localparam int RECOV_NS    = 125;
    localparam int SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CMD16_CYC   = (CMD16_NS * CLK_MHZ + 999) / 1000;
    localparam int CMD8_CYC    = (CMD8_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOV_CYC   = (RECOV_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_HOST_CLKS = 2;
    localparam int STEP_CYC    = 2;
    // ******************************
    // Decode and reset values
    // ******************************
    localparam logic [23:0] ONE_MEG   = 24'h100000;
    localparam logic [23:0] BOOT_BASE = 24'h0F0000;
    localparam logic [15:0] PORT_RTC_ADDR = 16'h0070;
    localparam logic [15:0] PORT_RTC_DATA = 16'h0071;
    localparam logic [2:0]  DACK_IDLE = 3'h4;
    localparam logic [7:0]  REF_ADDR_RST = 8'h00;
    localparam logic [15:0] IRQ_INVERT = 16'h0100;
    // ******************************
    // Synchroniser bit positions
    // ******************************
    localparam int SY_MASTER = 0;
    localparam int SY_RDY    = 1;
    localparam int SY_CHK    = 2;
    localparam int SY_MCS16  = 3;
    localparam int SY_REF    = 4;
    localparam int SY_IOR    = 5;
    localparam int SY_IOW    = 6;
    localparam int SY_MEMR   = 7;
    localparam int SY_MEMW   = 8;
    localparam int SY_W      = 9;
    localparam logic [8:0] SY_RST = 9'h1FF;
endpackage

// [rtl/ibi_mux_if.sv]
// Phase of the request multiplexer, from divider to demultiplexer.
// Both ends run on the system clock.
`timescale 1ns/1ps
interface ibi_mux_if;
    logic [1:0] phase;
    logic       slot_end;
    modport gen  (output phase, output slot_end);
    modport take (input phase, input slot_end);
endinterface

// [rtl/ibi_clk_div.sv]
// Divider making the bus clock and its double-rate companion.
// Runs on the system clock; phase doubles as the mux select.
`timescale 1ns/1ps
module ibi_clk_div (
    // System
    input  wire logic clk_sys,
    input  wire logic reset,
    // Phase out
    ibi_mux_if.gen    mux,
    // Pins
    output logic      expansion_bus_clock,
    output logic      expansion_bus_clock_double
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0] phase;
    } ibi_div_t;
    ibi_div_t r_r, r_nxt;

    always_comb begin
        r_nxt = r_r;
        if (r_r.cnt == 2'(ibi_pkg::STEP_CYC - 1)) begin
            r_nxt.cnt   = 2'h0;
            r_nxt.phase = r_r.phase + 2'h1;
        end else begin
            r_nxt.cnt = r_r.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign mux.phase    = r_r.phase;
    assign mux.slot_end = (r_r.cnt == 2'(ibi_pkg::STEP_CYC - 1));
    assign expansion_bus_clock        = r_r.phase[1];
    assign expansion_bus_clock_double = r_r.phase[0];
endmodule // ibi_clk_div

// [rtl/ibi_req_demux.sv]
// Demultiplexer of interrupt and DMA request pins.
// Pins are asynchronous; phase comes from the divider.
`timescale 1ns/1ps
module ibi_req_demux (
    // System
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Phase in
    ibi_mux_if.take          mux,
    // Pins
    input  wire logic [3:0]  muxed_interrupt_requests,
    input  wire logic [1:0]  muxed_dma_requests,
    // To controllers
    output logic      [15:0] irq_to_controller,
    output logic      [7:0]  dreq_to_controller
);
    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [1:0]  ph1;
        logic [1:0]  ph2;
        logic        st1;
        logic        st2;
        logic [15:0] irq;
        logic [7:0]  dreq;
    } ibi_dmx_t;
    ibi_dmx_t r_r, r_nxt;

    always_comb begin
        r_nxt     = r_r;
        r_nxt.s1  = {muxed_dma_requests, muxed_interrupt_requests};
        r_nxt.s2  = r_r.s1;
        // Phase delayed to line up with the synchronised pins
        r_nxt.ph1 = mux.phase;
        r_nxt.ph2 = r_r.ph1;
        r_nxt.st1 = mux.slot_end;
        r_nxt.st2 = r_r.st1;
        for (int k = 0; k < 4; k++) begin
            if (r_r.st2 && r_r.ph2 == 2'(k)) begin
                r_nxt.irq[k*4 +: 4] = r_r.s2[3:0]
                                     ^ ibi_pkg::IRQ_INVERT[k*4 +: 4];
                r_nxt.dreq[k*2 +: 2] = r_r.s2[5:4];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign irq_to_controller  = r_r.irq;
    assign dreq_to_controller = r_r.dreq;
endmodule // ibi_req_demux

// [dv/ibi_card_model.sv]
// Card side model: ready stretching, read data, request muxing.
// Assumes the block's command and bus clock pins.
`timescale 1ns/1ps
module ibi_card_model (
    // Control
    input  wire logic        clk_sys, slow, sd_oe, iochrdy_oe,
    input  wire logic        memr_n_out, memw_n_out, ior_n_out, iow_n_out,
    input  wire logic        expansion_bus_clock, expansion_bus_clock_double,
    // Data
    input  wire logic [15:0] sd_out, rd_data, irq_pat,
    input  wire logic [7:0]  dreq_pat,
    output logic      [15:0] sd_in,
    output logic             iochrdy_in,
    output logic      [3:0]  muxed_interrupt_requests,
    output logic      [1:0]  muxed_dma_requests
);
    logic [7:0] cnt_r;
    logic       rd, cmd;
    logic [1:0] ph;
    assign rd = !memr_n_out || !ior_n_out;
    assign cmd = rd || !memw_n_out || !iow_n_out;
    assign ph = {expansion_bus_clock, expansion_bus_clock_double};
    always @(posedge clk_sys) cnt_r <= cmd ? cnt_r + 8'h01 : 8'h00;
    assign iochrdy_in = !(slow && cmd && cnt_r < 8'h28) && !iochrdy_oe;
    // Released lanes show read data in a read and its inverse otherwise, never stale data
    assign sd_in = sd_oe ? sd_out : (rd ? rd_data : ~rd_data);
    assign muxed_interrupt_requests = irq_pat[{ph, 2'h0} +: 4];
    assign muxed_dma_requests = dreq_pat[{ph, 1'h0} +: 2];
endmodule // ibi_card_model

// [dv/ibi_properties.sv]
// Checker of the expansion bus interface pins.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module ibi_properties (
    // System
    input wire logic        clk_sys, reset,
    // Ownership
    input wire logic        master_owner, dma_owner, la_oe, sa_oe, cmd_oe, aen, ale,
    // Cycle
    input wire logic [6:0]  la_out,
    input wire logic [19:0] sa_out,
    input wire logic        smemr_n, smemw_n, memr_n_out, iow_n_out, ref_n_oe,
    input wire logic        host_bus_claim, clock_chip_write_strobe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    upper_addr_a: assert property (la_oe == !master_owner)
        else $error("upper address drive");
    low_pins_a: assert property (sa_oe == la_oe && cmd_oe == la_oe)
        else $error("low pin drive");
    addr_enable_a: assert property (aen == dma_owner)
        else $error("address enable");
    owner_ale_a: assert property (
        $past(dma_owner || master_owner) && (dma_owner || master_owner) |-> ale)
        else $error("latch enable low");
    smemr_gate_a: assert property (!smemr_n |-> la_out[6:3] == 4'h0 || ref_n_oe)
        else $error("read above limit");
    smemw_gate_a: assert property (!smemw_n |-> la_out[6:3] == 4'h0)
        else $error("write above limit");
    refresh_read_a: assert property (ref_n_oe |-> !memr_n_out)
        else $error("refresh without read");
    claim_two_a: assert property (
        $rose(host_bus_claim) |=> host_bus_claim ##1 !host_bus_claim)
        else $error("claim length");
    rtc_write_a: assert property (
        !clock_chip_write_strobe_n |-> !iow_n_out && sa_out[15:0] == 16'h0071)
        else $error("clock chip write");
endmodule // ibi_properties

bind isa_bus_interface ibi_properties ibi_properties_inst (.*);

// [dv/tb_top.sv]
// Self-checking bench for the expansion bus interface.
// Assumes the card model and the bound checker.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, reset, req_valid, req_ready, req_is_io, req_write, req_bhe, req_done;
    logic refresh_req, host_bus_claim, dma_owner, dma_last, terminal_count, master_owner;
    logic master_target_hit, master_access_done, nmi_enable, nmi, la_oe, sa_oe, sd_oe, slow;
    logic sbhe_n_in, sbhe_n_out, memr_n_in, memw_n_in, ior_n_in, iow_n_in, memr_n_out;
    logic memw_n_out, ior_n_out, iow_n_out, cmd_oe, smemr_n, smemw_n, ale, aen, iochrdy_in;
    logic iochrdy_out, iochrdy_oe, ref_n_in, ref_n_out, ref_n_oe, m_ref_n, master_n, mcs16_n;
    logic iochck_n, clock_chip_address_strobe_n, clock_chip_write_strobe_n;
    logic clock_chip_data_strobe_n, boot_or_clock_chip_select_n, expansion_bus_clock;
    logic expansion_bus_clock_double;
    logic [23:0] req_addr;
    logic [19:0] master_addr, sa_in, sa_out, m_sa;
    logic [15:0] req_wdata, req_rdata, sd_in, sd_out, rd_data, irq_pat, irq_to_controller, wd;
    logic [10:0] seen;
    logic [7:0]  refresh_addr, dreq_to_controller, dreq_pat;
    logic [6:0]  la_out;
    logic [3:0]  master_strobes, muxed_interrupt_requests, m_cmd_n;
    logic [2:0]  dma_channel, encoded_dma_acknowledges;
    logic [1:0]  muxed_dma_requests;
    int          mismatches, cmp_count, claims;
    assign {memr_n_in, memw_n_in, ior_n_in, iow_n_in} =
        cmd_oe ? {memr_n_out, memw_n_out, ior_n_out, iow_n_out} : m_cmd_n;
    assign sa_in = sa_oe ? sa_out : m_sa;
    assign ref_n_in = m_ref_n && !ref_n_oe;
    isa_bus_interface isa_bus_interface_inst (.*);
    ibi_card_model ibi_card_model_inst (.*);
    always #12.5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        seen <= seen | {!sbhe_n_out, aen, ref_n_oe && !memr_n_out,
            encoded_dma_acknowledges == 3'h3, terminal_count, !boot_or_clock_chip_select_n,
            !clock_chip_data_strobe_n, !clock_chip_write_strobe_n,
            !clock_chip_address_strobe_n, !smemw_n, !smemr_n};
        claims <= claims + int'(host_bus_claim);
        if (sd_oe) wd <= sd_out;
    end
    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Entry: dma, io, write, address, expected event set
    task automatic host_cyc(input logic [37:0] e, output logic [15:0] rd, output int n);
        @(posedge clk_sys);
        seen = '0;
        {dma_owner, dma_last, req_is_io, req_write, req_addr} <= {e[37], e[37:11]};
        req_wdata <= ~e[26:11];
        req_valid <= 1'b1;
        do @(negedge clk_sys); while (!req_ready);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (!req_done && n < 400);
        rd = req_rdata;
        chk({5'h0, seen}, {5'h0, e[10:0]});
        chk({15'h0, req_done}, 16'h1);
        if (e[35] && !e[37]) chk(wd, ~e[26:11]);
    endtask
    task automatic t_decode;
        logic [37:0] tab [9];
        logic [15:0] rd;
        int          n, n0;
        tab = '{{3'h0, 24'h000010, 11'h401}, {3'h0, 24'h0F0010, 11'h421},
            {3'h0, 24'h200000, 11'h400}, {3'h1, 24'h200000, 11'h400},
            {3'h1, 24'h000400, 11'h402}, {3'h4, 24'h000100, 11'h6C1},
            {3'h3, 24'h000070, 11'h424}, {3'h3, 24'h000071, 11'h428},
            {3'h2, 24'h000071, 11'h430}};
        foreach (tab[i]) begin
            host_cyc(tab[i], rd, n);
            if (i == 0) n0 = n;
            if (!tab[i][35] && !tab[i][37]) chk(rd, rd_data);
        end
        @(posedge clk_sys);
        slow <= 1'b1;
        host_cyc(tab[0], rd, n);
        chk(rd, rd_data);
        chk({15'h0, n > n0 + 15}, 16'h1);
        @(posedge clk_sys);
        slow    <= 1'b0;
        mcs16_n <= 1'b0;
        host_cyc(tab[0], rd, n);
        chk(16'(n), 16'(n0 - ibi_pkg::CMD8_CYC + ibi_pkg::CMD16_CYC));
        host_cyc(tab[8], rd, n);
        chk(16'(n), 16'(n0));
        @(posedge clk_sys);
        mcs16_n <= 1'b1;
    endtask
    task automatic t_refresh;
        logic [7:0] ra;
        @(posedge clk_sys);
        seen = '0;
        claims = 0;
        ra = refresh_addr;
        refresh_req <= 1'b1;
        @(posedge clk_sys);
        refresh_req <= 1'b0;
        repeat (3) @(negedge clk_sys);
        for (int n = 0; n < 200 && !req_ready; n++) @(negedge clk_sys);
        chk({15'h0, req_ready}, 16'h1);
        chk(16'(claims), 16'h2);
        chk({5'h0, seen}, 16'h101);
        chk({8'h0, refresh_addr}, {8'h0, ra + 8'h01});
    endtask
    task automatic t_master;
        @(posedge clk_sys);
        master_n <= 1'b0;
        m_sa <= 20'h0C350;
        repeat (5) @(negedge clk_sys);
        chk({11'h0, la_oe, sa_oe, cmd_oe, ale, master_owner}, 16'h0003);
        @(posedge clk_sys);
        m_cmd_n <= 4'h7;
        master_target_hit <= 1'b1;
        repeat (5) @(negedge clk_sys);
        chk({master_strobes, master_addr[11:0]}, 16'h4350);
        chk({15'h0, iochrdy_oe}, 16'h1);
        @(posedge clk_sys);
        master_access_done <= 1'b1;
        m_cmd_n <= 4'hF;
        repeat (2) @(negedge clk_sys);
        chk({15'h0, iochrdy_oe}, 16'h0);
        @(posedge clk_sys);
        claims = 0;
        m_ref_n <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk(16'(claims), 16'h2);
        @(posedge clk_sys);
        {master_n, m_ref_n, master_target_hit, master_access_done} <= 4'hC;
        repeat (5) @(negedge clk_sys);
    endtask
    task automatic t_side;
        @(posedge clk_sys);
        iochck_n <= 1'b0;
        irq_pat <= 16'h1E6B;
        dreq_pat <= 8'h9C;
        repeat (4) @(negedge clk_sys);
        chk({15'h0, nmi}, 16'h0);
        @(posedge clk_sys);
        nmi_enable <= 1'b1;
        repeat (30) @(negedge clk_sys);
        chk({15'h0, nmi}, 16'h1);
        chk(irq_to_controller, 16'h1F6B);
        chk({8'h0, dreq_to_controller}, 16'h009C);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {clk_sys, reset, req_valid, req_is_io, req_write, refresh_req, dma_owner} = 7'h20;
        {dma_last, req_bhe, master_target_hit, master_access_done, nmi_enable, slow} = 6'h10;
        {sbhe_n_in, m_ref_n, master_n, mcs16_n, iochck_n, m_cmd_n} = 9'h1FF;
        {req_addr, req_wdata, m_sa, irq_pat, dreq_pat} = '0;
        {dma_channel, rd_data, seen} = {3'h3, 16'h5AC3, 11'h0};
        {claims, mismatches, cmp_count} = '0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        t_decode;
        t_refresh;
        t_master;
        t_side;
        end_of_test;
    end
    initial begin
        #250000;
        mismatches++;
        end_of_test;
    end
endmodule // tb_top
